/* fault_regs_pkg.sv */
// Register map, field positions and threshold table for the fault live status slice
package fault_regs_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] INPUT_OVERVOLTAGE_LIVE_STATUS_ADDR = 8'h35;
    localparam logic [7:0] BIAS_FAULT_LIVE_STATUS_ADDR = 8'h37;
    localparam logic [7:0] BIAS_OVERVOLTAGE_THRESHOLD_CFG_ADDR = 8'h55;
    localparam logic [7:0] INPUT_OVERVOLTAGE_LIVE_STATUS_RST = 8'h00;
    localparam logic [7:0] BIAS_FAULT_LIVE_STATUS_RST = 8'h00;
    localparam logic [7:0] BIAS_OVERVOLTAGE_THRESHOLD_CFG_RST = 8'h40;
    // Field positions
    localparam int CH1_OV_BIT = 7;
    localparam int CH2_OV_BIT = 6;
    localparam int BIAS_HIGH_CURRENT_BIT = 7;
    localparam int BIAS_LOW_CURRENT_BIT = 6;
    localparam int BIAS_OV_BIT = 5;
    localparam int THRESHOLD_LSB = 5;
    localparam int THRESHOLD_W = 3;
    localparam logic [2:0] THRESHOLD_CODE_RST = 3'h2;
    // Margin table in millivolts
    localparam logic [7:0] MARGIN_CODE0_MV = 8'h00;
    localparam logic [7:0] MARGIN_CODE1_MV = 8'h0a;
    localparam logic [7:0] MARGIN_CODE2_MV = 8'h28;
    localparam logic [7:0] MARGIN_STEP_MV = 8'h1e;
    localparam logic [7:0] MARGIN_CODE7_MV = 8'hbe;
endpackage : fault_regs_pkg

/* fault_flag_sync.sv */
// Two-stage synchroniser bank for asynchronous fault detector levels
`timescale 1ns/10ps
module fault_flag_sync
    import fault_regs_pkg::*;
#(
    parameter int WIDTH = 5
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
    logic [WIDTH-1:0] nxt_meta;
    logic [WIDTH-1:0] nxt_sync;

    // Hold while the clock enable is low
    always_comb begin
        nxt_meta = clk_en ? async_in : meta_ff;
        nxt_sync = clk_en ? meta_ff : sync_ff;
    end

    // Register both stages
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign sync_out = sync_ff;
endmodule : fault_flag_sync

/* bias_ov_margin.sv */
// Threshold code to overvoltage margin decoder for the bias supply comparator
`timescale 1ns/10ps
module bias_ov_margin
    import fault_regs_pkg::*;
(
    input wire logic [2:0] threshold_code,
    output logic [7:0] margin_mv
);
    // Codes 3 to 6 step up from the code 2 margin
    always_comb begin
        case (threshold_code)
            3'h0: margin_mv = MARGIN_CODE0_MV;
            3'h1: margin_mv = MARGIN_CODE1_MV;
            3'h2: margin_mv = MARGIN_CODE2_MV;
            3'h7: margin_mv = MARGIN_CODE7_MV;
            default: margin_mv = 8'(MARGIN_CODE2_MV
                + MARGIN_STEP_MV * 8'(threshold_code - 3'h2));
        endcase
    end
endmodule : bias_ov_margin

/* fault_live_status_and_ov_threshold.sv */
// Fault live status registers and bias overvoltage threshold configuration
// How it works
// - Bit 7 of the input overvoltage status reads one while channel 1 positive input is over voltage.
// - Bit 6 of the input overvoltage status reads one while channel 2 positive input is over voltage.
// - Bit 7 of the bias fault status reads one while a bias high-current fault is present.
// - Bit 6 of the bias fault status reads one while a bias low-current fault is present.
// - Bit 5 of the bias fault status reads one while a bias overvoltage fault is present.
// - Bits 7 to 5 of the threshold configuration hold a writable code that resets to 010b.
// - Codes 0, 1 and 2 give margins of 0, 10 and 40 mV above the programmed bias.
// - Codes 3 to 6 add 30 mV per code step.
// - Code 7 gives a 190 mV margin.
// - Reserved bits read zero and software writes only zero to them.
// - Status flags are live levels, not latched history.
`timescale 1ns/10ps
module fault_live_status_and_ov_threshold
    import fault_regs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wr_data,
    output logic [DATA_W-1:0] reg_rd_data,
    output logic reg_rd_hit,
    input wire logic ch1_positive_input_ov,
    input wire logic ch2_positive_input_ov,
    input wire logic bias_supply_high_current,
    input wire logic bias_supply_low_current,
    input wire logic bias_supply_ov,
    output logic [2:0] bias_overvoltage_threshold_code,
    output logic [7:0] bias_ov_margin_mv
);
    logic [4:0] raw_faults;
    logic [4:0] live_faults;
    logic [2:0] threshold_ff;
    logic [2:0] nxt_threshold;
    logic [DATA_W-1:0] rd_data_ff;
    logic [DATA_W-1:0] nxt_rd_data;
    logic rd_hit_ff;
    logic nxt_rd_hit;
    logic [DATA_W-1:0] ov_status;
    logic [DATA_W-1:0] bias_status;
    logic [DATA_W-1:0] cfg_value;
    logic [7:0] nxt_margin;
    logic [7:0] margin_ff;
    logic rd_take;
    logic wr_take;
    logic sel_ov_status;
    logic sel_bias_status;
    logic sel_threshold_cfg;
    logic sel_mapped;
    logic cfg_write;
    logic status_write;
    logic [2:0] wr_code;
    logic [DATA_W-1:0] rd_mux;

    assign raw_faults = {ch1_positive_input_ov, ch2_positive_input_ov,
        bias_supply_high_current, bias_supply_low_current, bias_supply_ov};

    // Detector levels come from the analog side
    fault_flag_sync #(
        .WIDTH(5)
    ) u_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .clk_en(clk_en),
        .async_in(raw_faults),
        .sync_out(live_faults)
    );

    // Qualified strobes and address decode
    always_comb begin
        rd_take = clk_en && reg_rd_en;
        wr_take = clk_en && reg_wr_en;
        sel_ov_status = (reg_addr == INPUT_OVERVOLTAGE_LIVE_STATUS_ADDR);
        sel_bias_status = (reg_addr == BIAS_FAULT_LIVE_STATUS_ADDR);
        sel_threshold_cfg = (reg_addr == BIAS_OVERVOLTAGE_THRESHOLD_CFG_ADDR);
        sel_mapped = sel_ov_status || sel_bias_status || sel_threshold_cfg;
        cfg_write = wr_take && sel_threshold_cfg;
        status_write = wr_take && (sel_ov_status || sel_bias_status); // Absorbed below
        wr_code = reg_wr_data[THRESHOLD_LSB +: THRESHOLD_W]; // Reserved write bits dropped
    end

    // Live status words, reserved bits zero
    always_comb begin
        ov_status = INPUT_OVERVOLTAGE_LIVE_STATUS_RST;
        bias_status = BIAS_FAULT_LIVE_STATUS_RST;
        ov_status[CH1_OV_BIT] = live_faults[4];
        ov_status[CH2_OV_BIT] = live_faults[3];
        bias_status[BIAS_HIGH_CURRENT_BIT] = live_faults[2];
        bias_status[BIAS_LOW_CURRENT_BIT] = live_faults[1];
        bias_status[BIAS_OV_BIT] = live_faults[0];
        cfg_value = '0;
        cfg_value[THRESHOLD_LSB +: THRESHOLD_W] = threshold_ff;
    end

    // Threshold code write path
    always_comb begin
        nxt_threshold = threshold_ff;
        // only the code field is stored
        if (cfg_write) begin
            nxt_threshold = wr_code;
        end else if (status_write) begin
            // status addresses have no write path
            nxt_threshold = threshold_ff;
        end
    end

    // One-hot read select, one slice per data bit
    for (genvar gb = 0; gb < DATA_W; gb++) begin : g_rd_bit
        assign rd_mux[gb] = (sel_ov_status && ov_status[gb])
            || (sel_bias_status && bias_status[gb])
            || (sel_threshold_cfg && cfg_value[gb]);
    end

    // Read data and hit, registered, cleared on the next cycle with the clock enable high
    always_comb begin
        nxt_rd_data = rd_data_ff;
        nxt_rd_hit = rd_hit_ff;
        if (clk_en) begin
            nxt_rd_data = '0;
            nxt_rd_hit = 1'b0;
        end
        if (rd_take && sel_mapped) begin
            nxt_rd_data = rd_mux;
            nxt_rd_hit = 1'b1;
        end
    end

    // Register state
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            threshold_ff <= THRESHOLD_CODE_RST;
            margin_ff <= MARGIN_CODE2_MV;
            rd_data_ff <= '0;
            rd_hit_ff <= 1'b0;
        end else begin
            threshold_ff <= nxt_threshold;
            margin_ff <= nxt_margin;
            rd_data_ff <= nxt_rd_data;
            rd_hit_ff <= nxt_rd_hit;
        end
    end

    bias_ov_margin u_margin (
        .threshold_code(nxt_threshold),
        .margin_mv(nxt_margin)
    );

    assign reg_rd_data = rd_data_ff;
    assign reg_rd_hit = rd_hit_ff;
    assign bias_overvoltage_threshold_code = threshold_ff;
    assign bias_ov_margin_mv = margin_ff; // Moves with the code
endmodule : fault_live_status_and_ov_threshold

/* fault_regs_props.sv */
// Checker for the fault live status and threshold register slice
`timescale 1ns/10ps
module fault_regs_props
    import fault_regs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wr_data,
    input wire logic [DATA_W-1:0] reg_rd_data,
    input wire logic reg_rd_hit,
    input wire logic ch1_positive_input_ov,
    input wire logic ch2_positive_input_ov,
    input wire logic bias_supply_high_current,
    input wire logic bias_supply_low_current,
    input wire logic bias_supply_ov,
    input wire logic [2:0] bias_overvoltage_threshold_code,
    input wire logic [7:0] bias_ov_margin_mv
);
    // Qualified strobes and short names
    wire rd = clk_en && reg_rd_en;
    wire wr = clk_en && reg_wr_en;
    wire [1:0] ov = {ch1_positive_input_ov, ch2_positive_input_ov};
    wire [2:0] bf = {bias_supply_high_current, bias_supply_low_current, bias_supply_ov};
    wire [2:0] code = bias_overvoltage_threshold_code;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    // Live flags after a settled input, reserved bits zero
    ov_live_bits_a: assert property ((clk_en && $stable(ov))[*4] ##0 (rd && reg_addr == 8'h35)
        |=> reg_rd_data == {$past(ov), 6'h00} && reg_rd_hit) else $error("input status wrong");
    bias_live_bits_a: assert property ((clk_en && $stable(bf))[*4] ##0 (rd && reg_addr == 8'h37)
        |=> reg_rd_data == {$past(bf), 5'h00} && reg_rd_hit) else $error("bias status wrong");
    cfg_read_a: assert property (rd && reg_addr == 8'h55
        |=> reg_rd_data == {$past(code), 5'h00} && reg_rd_hit) else $error("config read wrong");
    cfg_write_a: assert property (wr && reg_addr == 8'h55
        |=> code == $past(reg_wr_data[7:5])) else $error("config write lost");
    ro_write_a: assert property (!(wr && reg_addr == 8'h55) |=> $stable(code))
        else $error("code changed without write");
    margin_low_a: assert property (code < 3'h3
        |-> bias_ov_margin_mv == (code == 3'h0 ? 8'h00 : code == 3'h1 ? 8'h0a : 8'h28))
        else $error("low margin wrong");
    margin_step_a: assert property (code inside {[3'h3:3'h6]}
        |-> bias_ov_margin_mv == 8'h28 + 8'h1e * ({5'h00, code} - 8'h02)) else $error("step margin wrong");
    margin_top_a: assert property (code == 3'h7 |-> bias_ov_margin_mv == 8'hbe)
        else $error("top margin wrong");
    // Main scenarios reached
    cover property (wr && reg_addr == 8'h55 && reg_wr_data[7:5] == 3'h7);
    cover property (rd && reg_addr == 8'h35 ##1 reg_rd_data[7]);
    cover property (rd && reg_addr == 8'h37 ##1 reg_rd_data[5]);
endmodule : fault_regs_props

bind fault_live_status_and_ov_threshold fault_regs_props chk_u (.*);

/* fault_live_status_and_ov_threshold_test.sv */
// Self-checking bench for the fault live status and threshold registers
`timescale 1ns/10ps
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin \
    $display("[FAIL] %s exp %h got %h", n, e, a); num_errors++; end end
module fault_live_status_and_ov_threshold_test;
    import fault_regs_pkg::*;
    logic ref_clk = 0, reset = 1, clk_en = 1, reg_wr_en = 0, reg_rd_en = 0, reg_rd_hit, hit;
    logic [7:0] reg_addr = 0, reg_wr_data = 0, reg_rd_data, bias_ov_margin_mv, got;
    logic [4:0] flt = 0;
    logic [2:0] bias_overvoltage_threshold_code;
    logic [7:0] mv [8] = '{8'h00, 8'h0a, 8'h28, 8'h46, 8'h64, 8'h82, 8'ha0, 8'hbe};
    logic [4:0] pat [4] = '{5'h1f, 5'h15, 5'h0a, 5'h00};
    int num_errors = 0, samples_checked = 0;
    always #10 ref_clk = ~ref_clk;
    fault_live_status_and_ov_threshold dut_u (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
        .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
        .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .reg_rd_hit(reg_rd_hit),
        .ch1_positive_input_ov(flt[4]), .ch2_positive_input_ov(flt[3]),
        .bias_supply_high_current(flt[2]), .bias_supply_low_current(flt[1]),
        .bias_supply_ov(flt[0]), .bias_overvoltage_threshold_code(bias_overvoltage_threshold_code),
        .bias_ov_margin_mv(bias_ov_margin_mv));
    // One read strobe, answer taken the cycle after
    task automatic rd(input logic [7:0] a);
        @(negedge ref_clk);
        reg_addr = a;
        reg_rd_en = 1;
        @(negedge ref_clk);
        reg_rd_en = 0;
        got = reg_rd_data;
        hit = reg_rd_hit;
    endtask : rd
    // One write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wr_data = d;
        reg_wr_en = 1;
        @(negedge ref_clk);
        reg_wr_en = 0;
    endtask : wr
    // Verdict and end of run
    task automatic end_sim;
        if (num_errors == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_sim
    // Hang guard
    initial begin
        #1ms;
        num_errors++;
        end_sim();
    end
    // Main sequence
    initial begin
        repeat (5) @(posedge ref_clk);
        @(negedge ref_clk);
        reset = 0;
        rd(8'h35); `CHK("ov status reset", 8'h00, got)
        rd(8'h37); `CHK("bias status reset", 8'h00, got)
        rd(8'h55); `CHK("cfg reset", 8'h40, got)
        `CHK("cfg hit", 1'b1, hit)
        `CHK("margin reset", 8'h28, bias_ov_margin_mv)
        rd(8'h36); `CHK("unmapped hit", 1'b0, hit)
        `CHK("unmapped data", 8'h00, got)
        // Every threshold code and its margin
        for (int c = 0; c < 8; c++) begin
            wr(8'h55, {c[2:0], 5'h00});
            rd(8'h55); `CHK("cfg readback", {c[2:0], 5'h00}, got)
            `CHK("margin", mv[c], bias_ov_margin_mv)
        end
        // Live flags follow inputs, writes to status change nothing
        foreach (pat[i]) begin
            flt = pat[i];
            repeat (3) @(negedge ref_clk);
            wr(8'h35, {~pat[i][4:3], 6'h00});
            wr(8'h37, {~pat[i][2:0], 5'h00});
            rd(8'h35); `CHK("ov status", {pat[i][4:3], 6'h00}, got)
            rd(8'h37); `CHK("bias status", {pat[i][2:0], 5'h00}, got)
        end
        // Write while the clock enable is low is not taken
        clk_en = 0;
        wr(8'h55, 8'h20);
        clk_en = 1;
        `CHK("code kept", 3'h7, bias_overvoltage_threshold_code)
        // Reset in mid-run restores the default code
        reset = 1;
        repeat (2) @(negedge ref_clk);
        reset = 0;
        rd(8'h55); `CHK("cfg after reset", 8'h40, got)
        `CHK("margin after reset", 8'h28, bias_ov_margin_mv)
        end_sim();
    end
endmodule : fault_live_status_and_ov_threshold_test
